// ===== design/fan_pwm_ramp_arbiter.sv
// Contract
// - Regulator hot while idle captures other-function duty
// - Enabling requests captured duty plus one step
// - Hot and enabled: step up each interval
// - Cool and enabled: step down each interval
// - Cool and below others: engine disables
// - Re-enable only after engine disabled itself
// - One engine per regulator input per output
// - Both regulators bound: take larger ramp duty
// - Throttle over threshold ramps like regulator
// - Fresh measurement under threshold starts ramp-down
// - Throttle inputs use own binding settings
// - Both throttles bound: take larger ramp duty
// - Manual override sets duty directly, may rise
// - Final duty zero to nonzero triggers spin-up; code never starts it under manual control
// - Spin-up holds programmed duty for programmed time
// - Final duty is max of active categories
// - Duty is 4-bit code, thirteen top
// - Boost, tach limit, override force full duty
`timescale 1ns/1ns
module fan_pwm_ramp_arbiter (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Hot inputs from pins, asynchronous
   input wire logic regulator_overtemp_1_in,
   input wire logic regulator_overtemp_2_in,
   // Throttle measurements, same clock
   input wire logic [7:0] cpu_throttle_1_level_in,
   input wire logic [7:0] cpu_throttle_2_level_in,
   input wire logic cpu_throttle_1_valid_in,
   input wire logic cpu_throttle_2_valid_in,
   input wire logic [7:0] cpu_throttle_1_limit_in,
   input wire logic [7:0] cpu_throttle_2_limit_in,
   // Full duty conditions
   input wire logic boost_temp_in,
   input wire logic tach_limit_in,
   input wire logic force_full_duty_in,
   // Ramp interval in milliseconds
   input wire logic [7:0] ramp_interval_ms_in,
   // Per output configuration
   input wire fan_ramp_pkg::fan_cfg_s fan_drive_1_cfg_in,
   input wire fan_ramp_pkg::fan_cfg_s fan_drive_2_cfg_in,
   // Final duty codes to the power stage
   output logic [3:0] fan_drive_1_duty_out,
   output logic [3:0] fan_drive_2_duty_out,
   output logic [1:0] spinup_active_out
);
   localparam int NFAN = 2;

   // Whole state of this module
   typedef struct packed {
      logic [2:0] reg1_sync;
      logic [2:0] reg2_sync;
      logic reg1_hot;
      logic reg2_hot;
      logic thr1_hot;
      logic thr2_hot;
      logic [17:0] tick_count;
      logic ms_tick;
      logic [1:0][3:0] final_duty;
      logic [1:0] spin_run;
      logic [1:0][7:0] spin_ms;
   } arb_state_s;

   arb_state_s st;
   arb_state_s next_st;
   fan_ramp_pkg::fan_cfg_s cfg [NFAN];
   logic [1:0][3:0] other_duty;
   logic [1:0][3:0] combined;
   logic [1:0][3:0][3:0] eng_duty;
   logic [1:0][3:0] eng_hot;

   assign cfg[0] = fan_drive_1_cfg_in;
   assign cfg[1] = fan_drive_2_cfg_in;

   function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
      max4 = (a > b) ? a : b;
   endfunction : max4

   // Engines per output: regulator 1, regulator 2, throttle 1, throttle 2
   // A source not bound to this output never heats its engine
   genvar f, e;
   generate
      for (f = 0; f < NFAN; f++) begin : g_fan
         assign eng_hot[f][0] = st.reg1_hot && cfg[f].bind_sel.regulator[0];
         assign eng_hot[f][1] = st.reg2_hot && cfg[f].bind_sel.regulator[1];
         assign eng_hot[f][2] = st.thr1_hot && cfg[f].bind_sel.throttle[0];
         assign eng_hot[f][3] = st.thr2_hot && cfg[f].bind_sel.throttle[1];
         for (e = 0; e < 4; e++) begin : g_eng
            ramp_engine u_eng (
               .clk_in(clk_in),
               .rst_n_in(rst_n_in),
               .ms_tick_in(st.ms_tick),
               .hot_in(eng_hot[f][e]),
               .other_duty_in(other_duty[f]),
               .interval_ms_in(ramp_interval_ms_in),
               .active_out(),
               .duty_out(eng_duty[f][e])
            );
         end
      end
   endgenerate

   // Arbitration of the categories for each output
   always_comb begin
      for (int i = 0; i < NFAN; i++) begin
         if (cfg[i].manual_en) begin
            other_duty[i] = cfg[i].manual_duty;
         end else if (st.spin_run[i]) begin
            other_duty[i] = max4(cfg[i].spinup_duty, cfg[i].auto_duty);
         end else begin
            other_duty[i] = cfg[i].auto_duty;
         end
         // Ramps and full duty stay out of other_duty, or an engine would chase itself
         combined[i] = max4(max4(eng_duty[i][0], eng_duty[i][1]),
                            max4(eng_duty[i][2], eng_duty[i][3]));
         combined[i] = max4(combined[i], other_duty[i]);
         if (boost_temp_in || tach_limit_in || force_full_duty_in) begin
            combined[i] = fan_ramp_pkg::DUTY_FULL;
         end
         if (combined[i] > fan_ramp_pkg::DUTY_FULL) begin
            combined[i] = fan_ramp_pkg::DUTY_FULL;
         end
      end
   end

   // Synchronisers, throttle compare, tick and spin-up timers
   always_comb begin
      next_st = st;
      // Pin inputs move only when the second and third stages agree
      next_st.reg1_sync = {st.reg1_sync[1:0], regulator_overtemp_1_in};
      next_st.reg2_sync = {st.reg2_sync[1:0], regulator_overtemp_2_in};
      if (st.reg1_sync[1] == st.reg1_sync[2]) begin
         next_st.reg1_hot = st.reg1_sync[2];
      end
      if (st.reg2_sync[1] == st.reg2_sync[2]) begin
         next_st.reg2_hot = st.reg2_sync[2];
      end
      // Throttle hot holds between measurements; only a fresh one changes it
      if (cpu_throttle_1_valid_in) begin
         next_st.thr1_hot = cpu_throttle_1_level_in > cpu_throttle_1_limit_in;
      end
      if (cpu_throttle_2_valid_in) begin
         next_st.thr2_hot = cpu_throttle_2_level_in > cpu_throttle_2_limit_in;
      end
      // Free running millisecond tick
      next_st.ms_tick = 1'b0;
      if (st.tick_count == fan_ramp_pkg::TICK_LAST) begin
         next_st.tick_count = '0;
         next_st.ms_tick = 1'b1;
      end else begin
         next_st.tick_count = st.tick_count + 18'h00001;
      end
      for (int i = 0; i < NFAN; i++) begin
         next_st.final_duty[i] = combined[i];
         // Spin-up counts whole milliseconds; zero length never runs
         if (st.spin_run[i]) begin
            if (st.ms_tick) begin
               next_st.spin_ms[i] = st.spin_ms[i] - fan_ramp_pkg::MS_ONE;
               if (st.spin_ms[i] <= fan_ramp_pkg::MS_ONE) begin
                  next_st.spin_run[i] = 1'b0;
               end
            end
         end
         if (!cfg[i].manual_en && st.final_duty[i] == fan_ramp_pkg::DUTY_OFF
             && combined[i] != fan_ramp_pkg::DUTY_OFF
             && cfg[i].spinup_ms != fan_ramp_pkg::MS_ZERO) begin
            next_st.spin_run[i] = 1'b1;
            next_st.spin_ms[i] = cfg[i].spinup_ms;
         end
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fan_drive_1_duty_out = st.final_duty[0];
   assign fan_drive_2_duty_out = st.final_duty[1];
   assign spinup_active_out = st.spin_run;

   // Full duty conditions reach both outputs one cycle later
   full_duty_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (boost_temp_in || tach_limit_in || force_full_duty_in) |=>
      (fan_drive_1_duty_out == fan_ramp_pkg::DUTY_FULL
       && fan_drive_2_duty_out == fan_ramp_pkg::DUTY_FULL))
      else $error("full duty not forced");

   // Output code never passes the top step
   duty_code_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      fan_drive_1_duty_out <= fan_ramp_pkg::DUTY_FULL
      && fan_drive_2_duty_out <= fan_ramp_pkg::DUTY_FULL)
      else $error("duty code above top step");

   // Manual value is a floor for either output
   manual_floor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'h1 |=>
      ((!$past(fan_drive_1_cfg_in.manual_en)
        || fan_drive_1_duty_out >= $past(fan_drive_1_cfg_in.manual_duty))
       && (!$past(fan_drive_2_cfg_in.manual_en)
        || fan_drive_2_duty_out >= $past(fan_drive_2_cfg_in.manual_duty))))
      else $error("output below manual duty");

   // Output takes at least the larger regulator ramp
   reg_max_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> (fan_drive_1_duty_out >= $past(eng_duty[0][0])
                && fan_drive_1_duty_out >= $past(eng_duty[0][1])))
      else $error("output below regulator ramps");

   // Second output takes at least its regulator ramps as well
   fan2_reg_max_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'h1 |=> (fan_drive_2_duty_out >= $past(eng_duty[1][0])
                && fan_drive_2_duty_out >= $past(eng_duty[1][1])))
      else $error("second output below regulator ramps");

   // Throttle ramps are a floor too
   thr_max_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> (fan_drive_2_duty_out >= $past(eng_duty[1][2])
                && fan_drive_2_duty_out >= $past(eng_duty[1][3])))
      else $error("output below throttle ramps");

   // First output takes at least its throttle ramps
   fan1_thr_max_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'h1 |=> (fan_drive_1_duty_out >= $past(eng_duty[0][2])
                && fan_drive_1_duty_out >= $past(eng_duty[0][3])))
      else $error("first output below throttle ramps");

   // Without manual control the automatic request is a floor, up to the top step
   auto_floor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !fan_drive_1_cfg_in.manual_en |=>
      (fan_drive_1_duty_out >= $past(fan_drive_1_cfg_in.auto_duty)
       || fan_drive_1_duty_out == fan_ramp_pkg::DUTY_FULL))
      else $error("output below automatic duty");

   // Zero to nonzero starts spin-up when a length is programmed
   spin_start_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!fan_drive_1_cfg_in.manual_en && st.final_duty[0] == fan_ramp_pkg::DUTY_OFF
       && combined[0] != fan_ramp_pkg::DUTY_OFF
       && fan_drive_1_cfg_in.spinup_ms != fan_ramp_pkg::MS_ZERO) |=> spinup_active_out[0])
      else $error("spin-up not triggered");

   // A running spin-up lifts the first output to its programmed duty
   spin_floor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (spinup_active_out[0] && !fan_drive_1_cfg_in.manual_en) |=>
      (fan_drive_1_duty_out >= $past(fan_drive_1_cfg_in.spinup_duty)
       || fan_drive_1_duty_out == fan_ramp_pkg::DUTY_FULL))
      else $error("spin-up duty not applied");

   // Manual control replaces spin-up, so it never starts under manual control
   spin_manual_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fan_drive_2_cfg_in.manual_en && !spinup_active_out[1]) |=> !spinup_active_out[1])
      else $error("spin-up started under manual control");

   // With no ramp and no full duty, manual control sets the output exactly
   manual_exact_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fan_drive_2_cfg_in.manual_en && eng_duty[1] == '0
       && !boost_temp_in && !tach_limit_in && !force_full_duty_in) |=>
      (fan_drive_2_duty_out == $past(fan_drive_2_cfg_in.manual_duty)))
      else $error("output not at manual duty");

   // A pin level counts only once the last two synchroniser stages agree
   pin_sync_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st.reg1_sync[1] != st.reg1_sync[2]) |=> $stable(st.reg1_hot))
      else $error("regulator level moved before the stages agreed");

   // Throttle level holds between fresh measurements
   thr_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !cpu_throttle_1_valid_in |=> $stable(st.thr1_hot))
      else $error("throttle level moved without a measurement");

   // A fresh measurement above the limit marks the throttle hot
   thr_fresh_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cpu_throttle_2_valid_in |=>
      (st.thr2_hot == ($past(cpu_throttle_2_level_in) > $past(cpu_throttle_2_limit_in))))
      else $error("throttle compare wrong");

   // Ticks never come back to back
   tick_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st.ms_tick |=> !st.ms_tick [*8])
      else $error("tick repeated too soon");

   // The tick follows the last divider count and nothing else
   tick_place_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'h1 |=> (st.ms_tick == ($past(st.tick_count) == fan_ramp_pkg::TICK_LAST)))
      else $error("tick out of place");

   // Divider never runs past its last count
   tick_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st.tick_count <= fan_ramp_pkg::TICK_LAST)
      else $error("tick divider overran");

   // Reset clears both outputs and any spin-up in one edge
   reset_quiet_a: assert property (@(posedge clk_in)
      !rst_n_in |=> (fan_drive_1_duty_out == fan_ramp_pkg::DUTY_OFF
                     && fan_drive_2_duty_out == fan_ramp_pkg::DUTY_OFF
                     && spinup_active_out == 2'h0))
      else $error("outputs not cleared by reset");
endmodule : fan_pwm_ramp_arbiter

// ===== design/fan_ramp_pkg.sv
package fan_ramp_pkg;

   // Duty step codes: zero is off, the top code is full duty
   localparam int DUTY_W = 4;
   localparam logic [3:0] DUTY_OFF = 4'h0;
   localparam logic [3:0] DUTY_MIN = 4'h1;
   localparam logic [3:0] DUTY_FULL = 4'hd;

   // Millisecond tick from the 250 MHz clock
   localparam int CLK_MHZ = 250;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int TICK_W = 18;
   localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

   // Interval of the ramp and of spin-up, in milliseconds
   localparam int MS_W = 8;
   localparam logic [7:0] MS_ZERO = 8'h00;
   localparam logic [7:0] MS_ONE = 8'h01;

   // Ramp engine state
   typedef struct packed {
      logic enabled;
      logic [3:0] duty;
      logic [7:0] ms_count;
   } ramp_state_s;

   // Bindings for one fan output: bit 0 source 1, bit 1 source 2
   typedef struct packed {
      logic [1:0] regulator;
      logic [1:0] throttle;
   } binding_s;

   // Per output configuration
   typedef struct packed {
      binding_s bind_sel;
      logic manual_en;
      logic [3:0] manual_duty;
      logic [3:0] auto_duty;
      logic [3:0] spinup_duty;
      logic [7:0] spinup_ms;
   } fan_cfg_s;

   typedef enum logic [1:0] {SPIN_IDLE, SPIN_RUN} spin_e;

endpackage : fan_ramp_pkg

// ===== design/ramp_engine.sv
`timescale 1ns/1ns
module ramp_engine (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ms_tick_in,
   // Control
   input wire logic hot_in,
   input wire logic [3:0] other_duty_in,
   input wire logic [7:0] interval_ms_in,
   // Result
   output logic active_out,
   output logic [3:0] duty_out
);
   fan_ramp_pkg::ramp_state_s st;
   fan_ramp_pkg::ramp_state_s next_st;
   logic step_due;

   // Step comes due once the programmed interval of ticks has passed
   always_comb begin
      step_due = ms_tick_in && (st.ms_count + fan_ramp_pkg::MS_ONE >= interval_ms_in);
   end

   // Enable on hot, ramp while enabled, drop out once cool and below the others
   always_comb begin
      next_st = st;
      if (!st.enabled) begin
         if (hot_in) begin
            next_st.enabled = 1'b1;
            next_st.ms_count = fan_ramp_pkg::MS_ZERO;
            if (other_duty_in >= fan_ramp_pkg::DUTY_FULL) begin
               next_st.duty = fan_ramp_pkg::DUTY_FULL;
            end else begin
               next_st.duty = other_duty_in + fan_ramp_pkg::DUTY_MIN;
            end
         end
      end else if (!hot_in && st.duty < other_duty_in) begin
         next_st.enabled = 1'b0;
         next_st.duty = fan_ramp_pkg::DUTY_OFF;
      end else begin
         if (ms_tick_in) begin
            next_st.ms_count = st.ms_count + fan_ramp_pkg::MS_ONE;
         end
         if (step_due) begin
            next_st.ms_count = fan_ramp_pkg::MS_ZERO;
            if (hot_in && st.duty < fan_ramp_pkg::DUTY_FULL) begin
               next_st.duty = st.duty + fan_ramp_pkg::DUTY_MIN;
            end else if (!hot_in && st.duty > fan_ramp_pkg::DUTY_MIN) begin
               next_st.duty = st.duty - fan_ramp_pkg::DUTY_MIN;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active_out = st.enabled;
   assign duty_out = st.enabled ? st.duty : fan_ramp_pkg::DUTY_OFF;

   // Enabling lands one step above the captured request
   enable_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!st.enabled && hot_in && other_duty_in < fan_ramp_pkg::DUTY_FULL) |=>
      (st.enabled && st.duty == $past(other_duty_in) + fan_ramp_pkg::DUTY_MIN))
      else $error("ramp did not enable at captured plus one");
   // Duty never leaves the legal code range while enabled
   duty_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st.enabled |-> (st.duty >= fan_ramp_pkg::DUTY_MIN && st.duty <= fan_ramp_pkg::DUTY_FULL))
      else $error("ramp duty out of range");
   // Hot while enabled never lowers the duty
   hot_no_fall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st.enabled && hot_in) |=> (st.duty >= $past(st.duty)))
      else $error("ramp fell while hot");
   // Cool while enabled never raises the duty
   cool_no_rise_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st.enabled && !hot_in) |=> (!st.enabled || st.duty <= $past(st.duty)))
      else $error("ramp rose while cool");
   // Stays enabled while hot
   stay_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st.enabled && hot_in) |=> st.enabled)
      else $error("ramp dropped while hot");
endmodule : ramp_engine

// ===== sim/fan_stage_model.sv
`timescale 1ns/1ns
module fan_stage_model (
   // Requests from the bench
   input wire logic [1:0] hot_req_in,
   // Duty codes seen by the power stage
   input wire logic [3:0] fan_drive_1_duty_in,
   input wire logic [3:0] fan_drive_2_duty_in,
   // Regulator thermal pins and stage health
   output logic regulator_overtemp_1_out,
   output logic regulator_overtemp_2_out,
   output int bad_codes_out
);
   initial bad_codes_out = 0;
   // Pins move off the clock grid, as a real thermal sensor would; never unknown after 3 ns
   assign #3 regulator_overtemp_1_out = hot_req_in[0];
   assign #3 regulator_overtemp_2_out = hot_req_in[1];
   // Codes above full duty are reserved and the stage cannot drive them
   always @(fan_drive_1_duty_in or fan_drive_2_duty_in) begin
      if (fan_drive_1_duty_in > 4'hd || fan_drive_2_duty_in > 4'hd) begin
         bad_codes_out = bad_codes_out + 1;
      end
   end
endmodule : fan_stage_model

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk_in;
   logic rst_n_in;
   logic [1:0] hot_req;
   logic hot1;
   logic hot2;
   logic [7:0] lvl1, lvl2, lim1, lim2, ivl;
   logic vld1, vld2, boost, tach, force_full;
   fan_ramp_pkg::fan_cfg_s cfg1, cfg2;
   logic [3:0] duty1, duty2, a;
   logic [1:0] spin;
   logic [9:0] exp_q[$];
   int num_errors = 0;
   int tests_run = 0;
   int head_age = 0;
   int seed = 23;
   int bad;
   int i;

   // Free-running 250 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   fan_pwm_ramp_arbiter u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .regulator_overtemp_1_in(hot1), .regulator_overtemp_2_in(hot2),
      .cpu_throttle_1_level_in(lvl1), .cpu_throttle_2_level_in(lvl2),
      .cpu_throttle_1_valid_in(vld1), .cpu_throttle_2_valid_in(vld2),
      .cpu_throttle_1_limit_in(lim1), .cpu_throttle_2_limit_in(lim2),
      .boost_temp_in(boost), .tach_limit_in(tach), .force_full_duty_in(force_full),
      .ramp_interval_ms_in(ivl), .fan_drive_1_cfg_in(cfg1), .fan_drive_2_cfg_in(cfg2),
      .fan_drive_1_duty_out(duty1), .fan_drive_2_duty_out(duty2),
      .spinup_active_out(spin));

   fan_stage_model u_stage (.hot_req_in(hot_req), .fan_drive_1_duty_in(duty1),
      .fan_drive_2_duty_in(duty2), .regulator_overtemp_1_out(hot1),
      .regulator_overtemp_2_out(hot2), .bad_codes_out(bad));

   // Oldest note is retired once outputs match it; a stale note is a mismatch
   always @(posedge clk_in) begin
      #1;
      if (exp_q.size() > 0) begin
         head_age = head_age + 1;
         if ({spin, duty1, duty2} === exp_q[0]) begin
            tests_run = tests_run + 1;
            head_age = 0;
            void'(exp_q.pop_front());
         end else if (head_age > 40) begin
            $display("[ERR] outputs expected %h seen %h", exp_q[0], {spin, duty1, duty2});
            num_errors = num_errors + 1;
            tests_run = tests_run + 1;
            head_age = 0;
            void'(exp_q.pop_front());
         end
      end
   end

   task automatic expect_out(input logic [1:0] s, input logic [3:0] d1, input logic [3:0] d2);
      exp_q.push_back({s, d1, d2});
   endtask : expect_out

   // Fixed wait, then a bounded wait for all notes to retire
   task automatic settle(input int n);
      repeat (n) @(negedge clk_in);
      for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(negedge clk_in);
      if (exp_q.size() > 0) begin
         num_errors = num_errors + 1;
         print_verdict();
      end
   endtask : settle

   // One-cycle fresh measurement on the chosen throttle inputs
   task automatic measure(input logic [1:0] which, input logic [7:0] l);
      lvl1 = l;
      lvl2 = l;
      vld1 = which[0];
      vld2 = which[1];
      @(negedge clk_in);
      vld1 = 1'b0;
      vld2 = 1'b0;
   endtask : measure

   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   // Main sequence, inputs move on the falling edge
   initial begin
      rst_n_in = 1'b0;
      hot_req = 2'b00;
      {lvl1, lvl2, vld1, vld2, boost, tach, force_full} = '0;
      lim1 = 8'h80;
      lim2 = 8'h80;
      ivl = 8'h02;
      cfg1 = '0;
      cfg2 = '0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      expect_out(2'b00, 4'h0, 4'h0);
      settle(2);
      for (i = 0; i < 3; i++) begin
         {boost, tach, force_full} = 3'b100 >> i;
         expect_out(2'b00, 4'hd, 4'hd);
         settle(1);
         {boost, tach, force_full} = 3'b000;
         expect_out(2'b00, 4'h0, 4'h0);
         settle(1);
      end
      // Manual value replaces the automatic one but full duty still wins
      for (i = 0; i < 4; i++) begin
         a = 4'h1 + 4'({$random(seed)} % 12);
         cfg1.auto_duty = a;
         cfg2.manual_en = 1'b1;
         cfg2.manual_duty = a;
         cfg2.auto_duty = 4'hd;
         expect_out(2'b00, a, a);
         settle(1);
         force_full = 1'b1;
         expect_out(2'b00, 4'hd, 4'hd);
         settle(1);
         force_full = 1'b0;
      end
      cfg2 = '0;
      cfg1.auto_duty = 4'h3;
      cfg1.bind_sel.regulator = 2'b01;
      cfg2.auto_duty = 4'h5;
      cfg2.bind_sel.regulator = 2'b10;
      expect_out(2'b00, 4'h3, 4'h5);
      settle(1);
      hot_req = 2'b01;
      expect_out(2'b00, 4'h4, 4'h5);
      settle(1);
      // A short drop of the pin must not recapture the lower value
      cfg1.auto_duty = 4'h1;
      hot_req = 2'b00;
      repeat (2) @(negedge clk_in);
      hot_req = 2'b01;
      repeat (20) @(negedge clk_in);
      expect_out(2'b00, 4'h4, 4'h5);
      settle(0);
      cfg1.auto_duty = 4'h6;
      cfg1.bind_sel.regulator = 2'b11;
      hot_req = 2'b11;
      expect_out(2'b00, 4'h7, 4'h6);
      settle(1);
      hot_req = 2'b00;
      cfg1.auto_duty = 4'h9;
      cfg2.auto_duty = 4'hc;
      expect_out(2'b00, 4'h9, 4'hc);
      settle(20);
      cfg1.auto_duty = 4'h2;
      cfg2.auto_duty = 4'h5;
      expect_out(2'b00, 4'h2, 4'h5);
      settle(20);
      cfg1.bind_sel = 4'b0001;
      cfg2.bind_sel = 4'b0011;
      measure(2'b01, 8'h80);
      repeat (20) @(negedge clk_in);
      expect_out(2'b00, 4'h2, 4'h5);
      settle(0);
      measure(2'b01, 8'h81);
      expect_out(2'b00, 4'h3, 4'h6);
      settle(1);
      cfg2.auto_duty = 4'h8;
      measure(2'b10, 8'hff);
      expect_out(2'b00, 4'h3, 4'h9);
      settle(1);
      measure(2'b11, 8'h00);
      cfg1.auto_duty = 4'hc;
      cfg2.auto_duty = 4'hc;
      expect_out(2'b00, 4'hc, 4'hc);
      settle(20);
      cfg1.auto_duty = 4'h0;
      cfg2.auto_duty = 4'h0;
      expect_out(2'b00, 4'h0, 4'h0);
      settle(20);
      // Start from a stopped fan so that spin-up fires
      cfg1.bind_sel = 4'b0000;
      cfg2.bind_sel = 4'b0000;
      cfg1.spinup_duty = 4'h7;
      cfg1.spinup_ms = 8'h01;
      cfg1.auto_duty = 4'h2;
      expect_out(2'b01, 4'h7, 4'h0);
      settle(1);
      tests_run = tests_run + 1;
      if (bad !== 0) begin
         $display("[ERR] reserved codes expected 0 seen %0d", bad);
         num_errors = num_errors + 1;
      end
      print_verdict();
   end
endmodule : tb_top
